// *** sim/udf_switch_model.sv ***
`timescale 1ns/10ps
// Contacts on the terminal pins: each change chatters before it settles
module udf_switch_model (
   // Clock
   input wire logic i_clk,
   // Requested contact state
   input wire logic [4:0] i_press,
   // Pin levels
   output logic [4:0] o_term
);
   logic [2:0] bounce [5];

   initial begin
      o_term = 5'h00;
      foreach (bounce[i]) begin
         bounce[i] = 3'h0;
      end
   end

   // Seven toggles per change, so one press must still give one step
   always @(posedge i_clk) begin
      for (int i = 0; i < 5; i++) begin
         if (bounce[i] != 3'h0) begin
            bounce[i] <= bounce[i] - 3'h1;
            o_term[i] <= (bounce[i] == 3'h1) ? i_press[i] : ~o_term[i];
         end else if (o_term[i] != i_press[i]) begin
            bounce[i] <= 3'h7;
            o_term[i] <= ~o_term[i];
         end
      end
   end
endmodule

// *** sim/udf_updown_ref_tb.sv ***
`timescale 1ns/10ps
`define UDF_CMP(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module udf_updown_ref_tb;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   typedef struct {string nm; int sel; logic [15:0] exp;} udf_note_type;
   localparam logic [15:0] MAXF = 16'h0800;
   localparam int TB_TICK = 8; // Short tick so the hybrid hold limit fits the run
   logic [15:0] max_f = MAXF;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] btn = 5'h00;
   wire logic [4:0] term;
   logic [29:0] func = {6'h00, 6'h00, udf_pkg::FN_CLEAR, udf_pkg::FN_LOWER, udf_pkg::FN_RAISE};
   logic [1:0] mode = 2'h1;
   logic save_en = 1'b1;
   logic [15:0] step_f = 16'h0000;
   logic step_wr = 1'b0;
   logic run = 1'b0;
   logic fault = 1'b0;
   logic ploss = 1'b0;
   logic jog = 1'b0;
   logic [15:0] jog_f = 16'h0000;
   logic [15:0] analog = 16'h0000;
   wire logic [15:0] cmd;
   wire logic [15:0] saved;
   wire logic valid, ud_act, up, dn;
   logic check_req = 1'b0;
   udf_note_type notes[$];
   int err_total = 0;
   int comparisons = 0;
   logic [15:0] s, a, a2, jf;

   udf_switch_model i_sw (.i_clk(clk), .i_press(btn), .o_term(term));
   udf_updown_ref #(.TICK_CYC(TB_TICK)) i_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_TERM(term), .I_TERM_FUNC(func),
      .I_UD_MODE(mode), .I_SAVE_EN(save_en), .I_MAX_FREQ(max_f), .I_STEP_FREQ(step_f), .I_STEP_WR(step_wr),
      .I_ACC_INC(16'h0040), .I_DEC_INC(16'h0040), .I_FORWARD_RUN_CMD(run), .I_FAULT_TRIP(fault),
      .I_POWER_LOSS(ploss), .I_JOG_ACTIVE(jog), .I_JOG_FREQ(jog_f), .I_ANALOG_VOLTAGE_INPUT(analog),
      .O_CMD_FREQ(cmd), .O_SAVED_FREQ(saved), .O_SAVED_VALID(valid), .O_UD_ACTIVE(ud_act),
      .O_RAMP_UP(up), .O_RAMP_DN(dn));

   // Clock, 4 ns period
   always #2 clk = ~clk;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [15:0] seen(input int sel);
      case (sel)
         0: seen = cmd;
         1: seen = saved;
         2: seen = {15'h0000, valid};
         3: seen = {15'h0000, ud_act};
         4: seen = {15'h0000, up};
         default: seen = {15'h0000, dn};
      endcase
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Note an expectation and ask the monitor to compare it
   task automatic chk(input string nm, input int sel, input logic [15:0] e);
      @(posedge clk);
      notes.push_back('{nm, sel, e});
      check_req <= 1'b1;
      @(posedge clk);
      check_req <= 1'b0;
   endtask

   // One press and release, long enough for the debouncer
   task automatic tap(input logic [4:0] m);
      btn <= btn | m;
      cyc(200);
      btn <= btn & ~m;
      cyc(200);
   endtask

   task automatic load_step(input logic [15:0] v);
      step_f <= v;
      step_wr <= 1'b1;
      @(posedge clk);
      step_wr <= 1'b0;
   endtask

   task automatic print_verdict();
      if (err_total == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Monitor: oldest note against the output it names
   always @(posedge clk) begin
      if (check_req) begin
         `UDF_CMP(notes[0].nm, notes[0].exp, seen(notes[0].sel))
         void'(notes.pop_front());
      end
   end

   // Watchdog, about 60000 cycles against some 35000 expected
   initial begin
      #240000;
      err_total++;
      print_verdict();
   end

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      s = $urandom(44);
      cyc(20);
      rst_n <= 1'b1;
      chk("cmd_after_reset", 0, 16'h0000);
      chk("valid_after_reset", 2, 16'h0000);
      s = 16'($urandom % 32'h0100) + 16'h0001;
      a = 16'($urandom % 32'h05ff) + 16'h0001;
      a2 = a + 16'h0100 + 16'($urandom % 32'h0100);
      jf = a2 + 16'h0001 + 16'($urandom % 32'h0100);
      load_step(s);
      run <= 1'b1;
      analog <= a;
      chk("cmd_no_select", 0, 16'h0000);
      chk("ud_active_run", 3, 16'h0001);
      tap(5'h01);
      chk("cmd_step_up", 0, s);
      tap(5'h01);
      chk("cmd_step_up2", 0, s + s);
      tap(5'h02);
      chk("cmd_step_dn", 0, s);
      tap(5'h02);
      tap(5'h02);
      chk("cmd_floor", 0, 16'h0000);
      mode <= 2'h2;
      tap(5'h01);
      chk("cmd_mode2_step", 0, s);
      tap(5'h03);
      chk("cmd_both_step", 0, s);
      // Fault saves s; a step taken during the trip is undone on recovery
      fault <= 1'b1;
      chk("saved_fault", 1, s);
      chk("valid_fault", 2, 16'h0001);
      tap(5'h01);
      fault <= 1'b0;
      cyc(2);
      chk("cmd_fault_back", 0, s);
      // Run off saves 2s and ignores lower
      tap(5'h01);
      run <= 1'b0;
      chk("saved_run_off", 1, s + s);
      tap(5'h02);
      chk("cmd_run_off", 0, s + s);
      run <= 1'b1;
      chk("cmd_run_back", 0, s + s);
      // Power loss saves s; the step taken while it lasts is undone
      tap(5'h02);
      ploss <= 1'b1;
      chk("saved_ploss", 1, s);
      tap(5'h01);
      ploss <= 1'b0;
      cyc(2);
      chk("cmd_ploss_back", 0, s);
      tap(5'h04);
      chk("cmd_clear", 0, 16'h0000);
      chk("saved_clear", 1, 16'h0000);
      chk("valid_clear", 2, 16'h0000);
      // Step written above maximum is capped then, not when applied
      load_step(16'hffff);
      max_f <= 16'hffff;
      tap(5'h01);
      chk("cmd_step_max", 0, MAXF);
      max_f <= MAXF;
      tap(5'h01);
      chk("cmd_ceiling", 0, MAXF);
      mode <= 2'h0;
      btn <= 5'h02;
      cyc(200);
      chk("ramp_dn_held", 5, 16'h0001);
      cyc(800);
      chk("cmd_ramp_floor", 0, 16'h0000);
      btn <= 5'h00;
      cyc(200);
      chk("ramp_dn_release", 5, 16'h0000);
      btn <= 5'h01;
      cyc(200);
      chk("ramp_up_held", 4, 16'h0001);
      cyc(800);
      chk("cmd_ramp_ceiling", 0, MAXF);
      btn <= 5'h03;
      cyc(300);
      chk("ramp_up_both", 4, 16'h0000);
      btn <= 5'h01;
      cyc(200);
      chk("ramp_up_again", 4, 16'h0001);
      btn <= 5'h00;
      cyc(200);
      chk("ramp_up_release", 4, 16'h0000);
      // Hybrid mode ramps only once raise is held past the hold limit
      mode <= 2'h2;
      btn <= 5'h01;
      cyc(200);
      chk("hybrid_wait", 4, 16'h0000);
      cyc(udf_pkg::HOLD_TICKS * TB_TICK);
      chk("hybrid_ramp", 4, 16'h0001);
      btn <= 5'h00;
      cyc(200);
      func <= {6'h00, udf_pkg::FN_SRC_SEL, udf_pkg::FN_CLEAR, udf_pkg::FN_LOWER, udf_pkg::FN_RAISE};
      mode <= 2'h1;
      load_step(s);
      chk("cmd_other_src", 0, a);
      chk("ud_active_other", 3, 16'h0000);
      btn <= 5'h08;
      cyc(200);
      analog <= a2;
      chk("cmd_select_hold", 0, a);
      tap(5'h01);
      chk("cmd_select_step", 0, a + s);
      btn <= 5'h00;
      cyc(200);
      chk("cmd_select_off", 0, a2);
      jog_f <= jf;
      jog <= 1'b1;
      chk("cmd_jog", 0, jf);
      chk("ud_active_jog", 3, 16'h0000);
      cyc(3);
      print_verdict();
   end
endmodule

// *** src/udf_debounce.sv ***
`timescale 1ns/10ps
module udf_debounce (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Tick and raw pin
   input wire logic i_tick,
   input wire logic i_pin,
   // Clean level
   output logic o_level
);
   localparam logic [3:0] DEB_LIM = 4'(udf_pkg::DEB_TICKS);

   logic sync_a;
   logic sync_b;
   logic [3:0] cnt;
   wire differs = sync_b != o_level;

   // Two-flop synchroniser, then accept only a level stable for the limit
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         cnt <= 4'h0;
         o_level <= 1'b0;
      end else begin
         sync_a <= i_pin;
         sync_b <= sync_a;
         if (!differs) begin
            cnt <= 4'h0;
         end else if (i_tick) begin
            if (cnt == DEB_LIM - 4'h1) begin
               o_level <= sync_b;
               cnt <= 4'h0;
            end else begin
               cnt <= cnt + 4'h1;
            end
         end
      end
   end
endmodule

// *** src/udf_pkg.sv ***
package udf_pkg;
   // ---------------------------------------------
   // Sizes
   // ---------------------------------------------
   localparam int unsigned NUM_TERM = 5;
   localparam int unsigned FUNC_W = 6;
   localparam int unsigned FREQ_W = 16; // 0.01 Hz units

   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned TICK_US = 1000; // Ramp and debounce tick period
   localparam int unsigned TICK_CYC = CLK_MHZ * TICK_US;
   localparam int unsigned HOLD_S = 3; // Hybrid mode hold limit
   localparam int unsigned HOLD_TICKS = HOLD_S * 1000000 / TICK_US;
   localparam int unsigned DEB_MS = 5; // Least stable time of a terminal
   localparam int unsigned DEB_TICKS = DEB_MS * 1000 / TICK_US;

   // ---------------------------------------------
   // Terminal function codes and reset values
   // ---------------------------------------------
   localparam logic [5:0] FN_RAISE = 6'h11;
   localparam logic [5:0] FN_LOWER = 6'h12;
   localparam logic [5:0] FN_CLEAR = 6'h14;
   localparam logic [5:0] FN_SRC_SEL = 6'h1b;
   localparam logic [15:0] STEP_RST = 16'h0000;
   localparam logic [15:0] FREQ_RST = 16'h0000;

   typedef enum logic [1:0] {
      UDF_NORMAL = 2'b00,
      UDF_STEP = 2'b01,
      UDF_STEP_NORM = 2'b10
   } udf_mode_type;

   typedef enum logic [1:0] {
      UDF_HOLD = 2'b00,
      UDF_UP = 2'b01,
      UDF_DN = 2'b10
   } udf_ramp_type;
endpackage

// *** src/udf_updown_ref.sv ***
`timescale 1ns/10ps
module udf_updown_ref #(
   parameter int unsigned TICK_CYC = udf_pkg::TICK_CYC
) (
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   // Terminal pins and their function codes
   input wire logic [4:0] I_TERM,
   input wire logic [29:0] I_TERM_FUNC,
   // Settings
   input wire logic [1:0] I_UD_MODE,
   input wire logic I_SAVE_EN,
   input wire logic [15:0] I_MAX_FREQ,
   input wire logic [15:0] I_STEP_FREQ,
   input wire logic I_STEP_WR,
   input wire logic [15:0] I_ACC_INC,
   input wire logic [15:0] I_DEC_INC,
   // Drive state
   input wire logic I_FORWARD_RUN_CMD,
   input wire logic I_FAULT_TRIP,
   input wire logic I_POWER_LOSS,
   input wire logic I_JOG_ACTIVE,
   input wire logic [15:0] I_JOG_FREQ,
   input wire logic [15:0] I_ANALOG_VOLTAGE_INPUT,
   // Results
   output logic [15:0] O_CMD_FREQ,
   output logic [15:0] O_SAVED_FREQ,
   output logic O_SAVED_VALID,
   output logic O_UD_ACTIVE,
   output logic O_RAMP_UP,
   output logic O_RAMP_DN
);
   localparam logic [17:0] TICK_LAST = 18'(TICK_CYC - 1);
   localparam logic [11:0] HOLD_LIM = 12'(udf_pkg::HOLD_TICKS);

   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   // Any terminal with this code whose level is high
   function automatic logic term_fn(input logic [29:0] f, input logic [4:0] lv, input logic [5:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 5; i++) begin
         if (f[i*6 +: 6] == code && lv[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b, input logic [15:0] m);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return (s > {1'b0, m}) ? m : s[15:0];
   endfunction

   function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
      return (b > a) ? 16'h0000 : a - b;
   endfunction

   // ------------------------------------------------
   // Tick divider and terminal conditioning
   // ------------------------------------------------
   logic [17:0] tick_cnt;
   logic tick;
   logic [4:0] lvl;

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         tick_cnt <= 18'h00000;
         tick <= 1'b0;
      end else begin
         tick <= tick_cnt == TICK_LAST;
         tick_cnt <= (tick_cnt == TICK_LAST) ? 18'h00000 : tick_cnt + 18'h00001;
      end
   end

   for (genvar g = 0; g < 5; g++) begin : g_term
      udf_debounce u_deb (
         .i_clk(I_CORE_CLK),
         .i_rst_n(I_RST_N),
         .i_tick(tick),
         .i_pin(I_TERM[g]),
         .o_level(lvl[g])
      );
   end

   // ------------------------------------------------
   // Function decode and edges
   // ------------------------------------------------
   logic raise_q, lower_q, clear_q, run_q, fault_q, pwr_q;
   logic [11:0] up_hold, dn_hold;
   logic [15:0] ud_freq, saved, step_freq;
   udf_pkg::udf_ramp_type dir;
   udf_pkg::udf_mode_type mode;

   assign mode = udf_pkg::udf_mode_type'(I_UD_MODE);
   wire raise = term_fn(I_TERM_FUNC, lvl, udf_pkg::FN_RAISE);
   wire lower = term_fn(I_TERM_FUNC, lvl, udf_pkg::FN_LOWER);
   wire clear = term_fn(I_TERM_FUNC, lvl, udf_pkg::FN_CLEAR);
   wire sel_on = term_fn(I_TERM_FUNC, lvl, udf_pkg::FN_SRC_SEL);
   wire sel_present = term_fn(I_TERM_FUNC, 5'h1f, udf_pkg::FN_SRC_SEL);
   wire ext_follow = sel_present && !sel_on;
   wire ud_ctrl = !ext_follow;
   wire run = I_FORWARD_RUN_CMD;
   wire active = run && ud_ctrl;
   wire only_up = raise && !lower;
   wire only_dn = lower && !raise;
   wire stepping = mode == udf_pkg::UDF_STEP || mode == udf_pkg::UDF_STEP_NORM;

   // Ramp when mode 0 or 3, or mode 2 once the hold limit is reached
   wire up_ramp = active && only_up && (!stepping || (mode == udf_pkg::UDF_STEP_NORM && up_hold == HOLD_LIM));
   wire dn_ramp = active && only_dn && (!stepping || (mode == udf_pkg::UDF_STEP_NORM && dn_hold == HOLD_LIM));
   wire step_up = active && stepping && raise && !raise_q && !lower;
   wire step_dn = active && stepping && lower && !lower_q && !raise;

   // Present motion; both inputs or neither means hold
   udf_pkg::udf_ramp_type next_dir;
   assign next_dir = up_ramp ? udf_pkg::UDF_UP : (dn_ramp ? udf_pkg::UDF_DN : udf_pkg::UDF_HOLD);

   wire steady = dir == udf_pkg::UDF_HOLD;
   wire save_ev = I_SAVE_EN && steady && ((run_q && !run) || (I_FAULT_TRIP && !fault_q) || (I_POWER_LOSS && !pwr_q));
   wire restart_ev = I_SAVE_EN && O_SAVED_VALID && ((run && !run_q) || (fault_q && !I_FAULT_TRIP) || (pwr_q && !I_POWER_LOSS));
   wire clr_ev = clear && !clear_q && run && steady;

   // ------------------------------------------------
   // Edge history and hold timers
   // ------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         {raise_q, lower_q, clear_q, run_q, fault_q, pwr_q} <= 6'h00;
         up_hold <= 12'h000;
         dn_hold <= 12'h000;
         dir <= udf_pkg::UDF_HOLD;
      end else begin
         {raise_q, lower_q, clear_q, run_q, fault_q, pwr_q} <= {raise, lower, clear, run, I_FAULT_TRIP, I_POWER_LOSS};
         up_hold <= !only_up ? 12'h000 : ((tick && up_hold != HOLD_LIM) ? up_hold + 12'h001 : up_hold);
         dn_hold <= !only_dn ? 12'h000 : ((tick && dn_hold != HOLD_LIM) ? dn_hold + 12'h001 : dn_hold);
         dir <= next_dir;
      end
   end

   // ------------------------------------------------
   // Step setting, capped at maximum frequency
   // ------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         step_freq <= udf_pkg::STEP_RST;
      end else if (I_STEP_WR) begin
         step_freq <= (I_STEP_FREQ > I_MAX_FREQ) ? I_MAX_FREQ : I_STEP_FREQ;
      end
   end

   // ------------------------------------------------
   // Up-down frequency
   // ------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         ud_freq <= udf_pkg::FREQ_RST;
      end else if (ext_follow) begin
         // Track the other source so turning select on freezes here
         ud_freq <= (I_ANALOG_VOLTAGE_INPUT > I_MAX_FREQ) ? I_MAX_FREQ : I_ANALOG_VOLTAGE_INPUT;
      end else if (clr_ev) begin
         ud_freq <= udf_pkg::FREQ_RST;
      end else if (restart_ev) begin
         ud_freq <= saved;
      end else if (tick && next_dir == udf_pkg::UDF_UP) begin
         ud_freq <= sat_add(ud_freq, I_ACC_INC, I_MAX_FREQ);
      end else if (tick && next_dir == udf_pkg::UDF_DN) begin
         ud_freq <= sat_sub(ud_freq, I_DEC_INC);
      end else if (step_up) begin
         ud_freq <= sat_add(ud_freq, step_freq, I_MAX_FREQ);
      end else if (step_dn) begin
         ud_freq <= sat_sub(ud_freq, step_freq);
      end
   end

   // ------------------------------------------------
   // Saved frequency; a save wins over a clear
   // ------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         saved <= udf_pkg::FREQ_RST;
         O_SAVED_VALID <= 1'b0;
      end else if (save_ev) begin
         saved <= ud_freq;
         O_SAVED_VALID <= 1'b1;
      end else if (clr_ev) begin
         saved <= udf_pkg::FREQ_RST;
         O_SAVED_VALID <= 1'b0;
      end
   end

   // ------------------------------------------------
   // Output selection, jog first
   // ------------------------------------------------
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_CMD_FREQ <= udf_pkg::FREQ_RST;
         O_UD_ACTIVE <= 1'b0;
         O_RAMP_UP <= 1'b0;
         O_RAMP_DN <= 1'b0;
      end else begin
         O_CMD_FREQ <= I_JOG_ACTIVE ? I_JOG_FREQ : (ext_follow ? I_ANALOG_VOLTAGE_INPUT : ud_freq);
         O_UD_ACTIVE <= ud_ctrl && !I_JOG_ACTIVE;
         O_RAMP_UP <= next_dir == udf_pkg::UDF_UP;
         O_RAMP_DN <= next_dir == udf_pkg::UDF_DN;
      end
   end
   assign O_SAVED_FREQ = saved;

   // ------------------------------------------------
   // Checks
   // ------------------------------------------------
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   jog_override_a: assert property (I_JOG_ACTIVE |=> O_CMD_FREQ == $past(I_JOG_FREQ))
      else $error("jog frequency not selected");
   src_follow_a: assert property (ext_follow && !I_JOG_ACTIVE |=> O_CMD_FREQ == $past(I_ANALOG_VOLTAGE_INPUT))
      else $error("other source not followed");
   both_hold_a: assert property (raise && lower |=> dir == udf_pkg::UDF_HOLD && !O_RAMP_UP && !O_RAMP_DN)
      else $error("ramp with both inputs");
   raise_ramp_a: assert property (active && only_up && mode == udf_pkg::UDF_NORMAL |=> O_RAMP_UP)
      else $error("no ramp up on raise");
   lower_ramp_a: assert property (active && only_dn && mode == udf_pkg::UDF_NORMAL |=> O_RAMP_DN)
      else $error("no ramp down on lower");
   hybrid_wait_a: assert property (mode == udf_pkg::UDF_STEP_NORM && up_hold != HOLD_LIM |-> next_dir != udf_pkg::UDF_UP)
      else $error("hybrid ramp before hold limit");
   step_once_a: assert property (step_up && !ext_follow && !clr_ev && !restart_ev && !tick
      |=> ud_freq == sat_add($past(ud_freq), $past(step_freq), $past(I_MAX_FREQ)))
      else $error("step not applied once");
   freq_clamp_a: assert property (!$past(ext_follow) && $changed(ud_freq) |-> ud_freq <= $past(I_MAX_FREQ))
      else $error("frequency above maximum");
   save_store_a: assert property (save_ev |=> O_SAVED_VALID && saved == $past(ud_freq))
      else $error("frequency not saved");
   restart_load_a: assert property (restart_ev && !ext_follow && !clr_ev |=> ud_freq == $past(saved))
      else $error("restart not at saved frequency");
endmodule
